// >>> shared/daq_pkg.sv
// Package: constants for the acquisition board data and pacing block
package daq_pkg;
    // ------------------------------------------------------------------
    // Converter coding
    // ------------------------------------------------------------------
    localparam int          CONV_BITS      = 12;
    localparam int          WORD_BITS      = 16;
    localparam int          NATIVE_SHIFT   = 4;
    localparam logic [11:0] CODE_MIN       = 12'h000;
    localparam logic [11:0] CODE_MAX       = 12'hFFF;
    localparam logic [11:0] CODE_MID       = 12'h800;
    localparam logic [11:0] DAC_RESET_CODE = 12'h000;
    // ------------------------------------------------------------------
    // Digital ports
    // ------------------------------------------------------------------
    localparam int          DIN_BITS       = 3;
    localparam int          DOUT_BITS      = 4;
    localparam logic [3:0]  DOUT_RESET     = 4'h0;
    // ------------------------------------------------------------------
    // Interval timer
    // ------------------------------------------------------------------
    localparam int          NUM_COUNTERS   = 3;
    localparam int          CNT_BITS       = 16;
    localparam logic [15:0] CNT_RESET      = 16'hFFFF;
    localparam logic [15:0] CNT_MIN_SINGLE = 16'h0002;
    localparam logic [15:0] CNT_MIN_CHAIN  = 16'h0002;
    localparam int          SYS_CLK_HZ     = 40_000_000;
    localparam int          OSC_HZ         = 1_000_000;
    localparam int          OSC_DIV        = SYS_CLK_HZ / OSC_HZ;
    localparam int          OSC_DIV_BITS   = 6;
    // Pacing source select
    localparam logic [1:0]  PACE_CTR2      = 2'h0;
    localparam logic [1:0]  PACE_CHAIN     = 2'h1;
    localparam logic [1:0]  PACE_EXT       = 2'h2;
    // Write select for counter load
    localparam logic [1:0]  SEL_CTR0       = 2'h0;
    localparam logic [1:0]  SEL_CTR1       = 2'h1;
    localparam logic [1:0]  SEL_CTR2       = 2'h2;
endpackage

// >>> rtl/rate_counter.sv
// Rate-generator down counter with gate and level-sensitive tick enable input
module rate_counter
#(
    parameter int WIDTH = daq_pkg::CNT_BITS
)(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Control
    input  wire logic             tick_i,
    input  wire logic             gate_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] reload_i,
    // Status
    output logic      [WIDTH-1:0] count_o,
    output logic                  pulse_o
);
    import daq_pkg::*;

    logic [WIDTH-1:0] period_reg, period_next;
    logic [WIDTH-1:0] count_reg,  count_next;
    logic             pulse_reg,  pulse_next;

    always_comb
    begin
        period_next = period_reg;
        count_next  = count_reg;
        pulse_next  = 1'b0;
        if (load_i)
        begin
            period_next = reload_i;
            count_next  = reload_i;
        end
        else if (tick_i && gate_i)
        begin
            if (count_reg <= WIDTH'(1))
            begin
                count_next = period_reg;
                pulse_next = 1'b1;
            end
            else
            begin
                count_next = count_reg - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            period_reg <= '1;
            count_reg  <= '1;
            pulse_reg  <= 1'b0;
        end
        else
        begin
            period_reg <= period_next;
            count_reg  <= count_next;
            pulse_reg  <= pulse_next;
        end
    end

    assign count_o = count_reg;
    assign pulse_o = pulse_reg;

    a_gate_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!gate_i && !load_i) |=> (count_reg == $past(count_reg)))
        else $error("Counter moved while gate low");
endmodule // rate_counter

// >>> rtl/daq_core.sv
// Digital side of the acquisition board: coding, ports, timer and pacing
module daq_core
(
    // Clock and reset
    input  wire logic                           sys_clk_i,
    input  wire logic                           nrst_i,
    // Converter result
    input  wire logic                           adc_valid_i,
    input  wire logic [daq_pkg::CONV_BITS-1:0]  adc_code_i,
    output logic      [daq_pkg::WORD_BITS-1:0]  adc_word_o,
    output logic                                adc_word_valid_o,
    // Analog output loads
    input  wire logic                           dac0_wr_i,
    input  wire logic                           dac1_wr_i,
    input  wire logic [daq_pkg::WORD_BITS-1:0]  dac_data_i,
    output logic      [daq_pkg::CONV_BITS-1:0]  dac0_code_o,
    output logic      [daq_pkg::CONV_BITS-1:0]  dac1_code_o,
    // Digital ports
    input  wire logic                           dout_wr_i,
    input  wire logic [daq_pkg::WORD_BITS-1:0]  dout_data_i,
    input  wire logic                           din_bit_one_i,
    input  wire logic                           din_bit_two_i,
    input  wire logic                           din_bit_three_i,
    output logic      [daq_pkg::WORD_BITS-1:0]  din_word_o,
    output logic                                dout_bit_zero_o,
    output logic                                dout_bit_one_o,
    output logic                                dout_bit_two_o,
    output logic                                dout_bit_three_o,
    // Counter programming
    input  wire logic                           cnt_wr_i,
    input  wire logic [1:0]                     cnt_sel_i,
    input  wire logic [daq_pkg::CNT_BITS-1:0]   cnt_data_i,
    input  wire logic                           ctr2_osc_sel_i,
    input  wire logic [1:0]                     pace_src_i,
    // Counter connector pins
    input  wire logic                           counter_zero_clock_in_i,
    input  wire logic                           counter_one_clock_in_i,
    input  wire logic                           gate0_i,
    input  wire logic                           gate1_i,
    input  wire logic                           gate2_i,
    input  wire logic                           ext_pace_i,
    output logic                                counter_zero_out_o,
    output logic                                counter_one_out_o,
    output logic                                pacer_counter_out_o,
    output logic                                pace_tick_o,
    output logic      [daq_pkg::CNT_BITS-1:0]   cnt0_value_o,
    output logic      [daq_pkg::CNT_BITS-1:0]   cnt1_value_o,
    output logic      [daq_pkg::CNT_BITS-1:0]   cnt2_value_o
);
    import daq_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg, rst_n_reg;
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Data coding and ports
    // ------------------------------------------------------------------
    logic [WORD_BITS-1:0] adc_word_reg, adc_word_next;
    logic                 adc_vld_reg,  adc_vld_next;
    logic [CONV_BITS-1:0] dac0_reg, dac0_next, dac1_reg, dac1_next;
    logic [DOUT_BITS-1:0] dout_reg, dout_next;
    logic [WORD_BITS-1:0] din_reg,  din_next;

    always_comb
    begin
        adc_vld_next  = adc_valid_i;
        adc_word_next = adc_word_reg;
        if (adc_valid_i)
            adc_word_next = {adc_code_i, {NATIVE_SHIFT{1'b0}}};
        dac0_next = dac0_wr_i ? dac_data_i[CONV_BITS-1:0] : dac0_reg;
        dac1_next = dac1_wr_i ? dac_data_i[CONV_BITS-1:0] : dac1_reg;
        dout_next = dout_wr_i ? dout_data_i[DOUT_BITS-1:0] : dout_reg;
        din_next  = {{(WORD_BITS-DIN_BITS){1'b0}},
                     din_bit_three_i, din_bit_two_i, din_bit_one_i};
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            adc_word_reg <= 16'h0000;
            adc_vld_reg  <= 1'b0;
            dac0_reg     <= DAC_RESET_CODE;
            dac1_reg     <= DAC_RESET_CODE;
            dout_reg     <= DOUT_RESET;
            din_reg      <= 16'h0000;
        end
        else
        begin
            adc_word_reg <= adc_word_next;
            adc_vld_reg  <= adc_vld_next;
            dac0_reg     <= dac0_next;
            dac1_reg     <= dac1_next;
            dout_reg     <= dout_next;
            din_reg      <= din_next;
        end
    end

    // ------------------------------------------------------------------
    // Timer clock edges
    // ------------------------------------------------------------------
    // Pin clocks taken as synchronous; only rising edges count
    logic [OSC_DIV_BITS-1:0] osc_cnt_reg, osc_cnt_next;
    logic c0_in_reg, c1_in_reg, ext_reg, c0_out_d_reg, c2_out_d_reg;
    logic osc_tick, c0_tick, c1_tick, c2_tick, ext_tick;
    logic [NUM_COUNTERS-1:0] cnt_pulse;
    logic [CNT_BITS-1:0]     cnt_val [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] tick_vec, gate_vec, load_vec;

    always_comb
    begin
        osc_tick     = (osc_cnt_reg == OSC_DIV_BITS'(OSC_DIV - 1));
        osc_cnt_next = osc_tick ? '0 : osc_cnt_reg + OSC_DIV_BITS'(1);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            osc_cnt_reg  <= '0;
            c0_in_reg    <= 1'b0;
            c1_in_reg    <= 1'b0;
            ext_reg      <= 1'b0;
            c0_out_d_reg <= 1'b0;
            c2_out_d_reg <= 1'b0;
        end
        else
        begin
            osc_cnt_reg  <= osc_cnt_next;
            c0_in_reg    <= counter_zero_clock_in_i;
            c1_in_reg    <= counter_one_clock_in_i;
            ext_reg      <= ext_pace_i;
            c0_out_d_reg <= cnt_pulse[0];
            c2_out_d_reg <= cnt_pulse[2];
        end
    end

    // Chaining is external wiring, so the pin edges already carry it
    assign c0_tick  = counter_zero_clock_in_i & ~c0_in_reg;
    assign c1_tick  = counter_one_clock_in_i & ~c1_in_reg;
    assign c2_tick  = ctr2_osc_sel_i ? osc_tick : 1'b1;
    assign ext_tick = ext_pace_i & ~ext_reg;
    assign tick_vec = {c2_tick, c1_tick, c0_tick};
    assign gate_vec = {gate2_i, gate1_i, gate0_i};

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_COUNTERS; gi++)
        begin : g_cnt
            assign load_vec[gi] = cnt_wr_i && (cnt_sel_i == 2'(gi));
            rate_counter #(.WIDTH(CNT_BITS)) u_cnt (
                .clk_i    (sys_clk_i),
                .rst_n_i  (rst_n_reg),
                .tick_i   (tick_vec[gi]),
                .gate_i   (gate_vec[gi]),
                .load_i   (load_vec[gi]),
                .reload_i (cnt_data_i),
                .count_o  (cnt_val[gi]),
                .pulse_o  (cnt_pulse[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pacing select and outputs
    // ------------------------------------------------------------------
    // Counter output pins are low pulses one cycle wide, idle high; pace_tick_o is a high pulse, idle low
    logic pace_next, pace_reg, c0o_reg, c1o_reg, c2o_reg;
    logic [CNT_BITS-1:0] v0_reg, v1_reg, v2_reg;

    always_comb
    begin
        case (pace_src_i)
            PACE_CTR2:  pace_next = cnt_pulse[2];
            PACE_CHAIN: pace_next = cnt_pulse[1] | (cnt_pulse[0] & ~c0_out_d_reg);
            PACE_EXT:   pace_next = ext_tick;
            default:    pace_next = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            pace_reg <= 1'b0;
            c0o_reg  <= 1'b1;
            c1o_reg  <= 1'b1;
            c2o_reg  <= 1'b1;
            v0_reg   <= CNT_RESET;
            v1_reg   <= CNT_RESET;
            v2_reg   <= CNT_RESET;
        end
        else
        begin
            pace_reg <= pace_next;
            c0o_reg  <= ~cnt_pulse[0];
            c1o_reg  <= ~cnt_pulse[1];
            c2o_reg  <= ~cnt_pulse[2];
            v0_reg   <= cnt_val[0];
            v1_reg   <= cnt_val[1];
            v2_reg   <= cnt_val[2];
        end
    end

    // No overrun flag: a new sample simply replaces the old one
    assign adc_word_o          = adc_word_reg;
    assign adc_word_valid_o    = adc_vld_reg;
    assign dac0_code_o         = dac0_reg;
    assign dac1_code_o         = dac1_reg;
    assign din_word_o          = din_reg;
    assign dout_bit_zero_o     = dout_reg[0];
    assign dout_bit_one_o      = dout_reg[1];
    assign dout_bit_two_o      = dout_reg[2];
    assign dout_bit_three_o    = dout_reg[3];
    assign counter_zero_out_o  = c0o_reg;
    assign counter_one_out_o   = c1o_reg;
    assign pacer_counter_out_o = c2o_reg;
    assign pace_tick_o         = pace_reg;
    assign cnt0_value_o        = v0_reg;
    assign cnt1_value_o        = v1_reg;
    assign cnt2_value_o        = v2_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_native_low_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_reg)
        adc_word_o[3:0] == 4'h0)
        else $error("Native word low bits not zero");
    a_native_shift: assert property (@(posedge sys_clk_i) disable iff (!rst_n_reg)
        adc_valid_i |=> adc_word_o[15:4] == $past(adc_code_i))
        else $error("Native word does not hold code");
    a_dac_truncate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_reg)
        dac0_wr_i |=> dac0_code_o == $past(dac_data_i[11:0]))
        else $error("DAC code not truncated to twelve bits");
    a_dac_indep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_reg)
        (dac0_wr_i && !dac1_wr_i) |=> $stable(dac1_code_o))
        else $error("DAC channel one changed on channel zero load");
    a_din_upper: assert property (@(posedge sys_clk_i) disable iff (!rst_n_reg)
        din_word_o[15:3] == 13'h0000)
        else $error("Digital input upper bits not zero");
    a_dout_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_reg)
        dout_wr_i |=> dout_reg == $past(dout_data_i[3:0]))
        else $error("Digital output not updated on write");
    a_ext_pace: assert property (@(posedge sys_clk_i) disable iff (!rst_n_reg)
        (pace_src_i == PACE_EXT && ext_pace_i && !ext_reg) |=> pace_tick_o)
        else $error("External pacing edge lost");
    a_ctr2_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_reg)
        cnt_pulse[2] |=> !pacer_counter_out_o)
        else $error("Pacer output did not pulse");
endmodule // daq_core

// >>> sim/host_wiring.sv
// Host-side model: chain jumpers and external pacing clock
module host_wiring
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    // Jumper setting
    input  wire logic [2:0] chain_i,
    // Board pins
    input  wire logic       pacer_counter_out_i,
    output logic            counter_zero_clock_in_o,
    output logic            counter_one_clock_in_o,
    output logic            ext_pace_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_reg;
    // ------------------------------------------------------------------
    // Jumpers: 3 pacer to counter one, 4 pacer to counter zero
    // ------------------------------------------------------------------
    assign counter_one_clock_in_o  = (chain_i == 3'h3) ? pacer_counter_out_i : 1'b0;
    assign counter_zero_clock_in_o = (chain_i == 3'h4) ? pacer_counter_out_i : 1'b0;
    // ------------------------------------------------------------------
    // External clock, four cycles a period; stands low when unused
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            div_reg <= 2'h0;
        else if (chain_i == 3'h6)
            div_reg <= div_reg + 2'h1;
        else
            div_reg <= 2'h0;
    end
    assign ext_pace_o = div_reg[1];
endmodule // host_wiring

// >>> sim/testbench.sv
// Self-checking bench for the acquisition board core
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import daq_pkg::*;
    logic        sys_clk_i, nrst_i, adc_valid_i, dac0_wr_i, dac1_wr_i, dout_wr_i, cnt_wr_i, ctr2_osc_sel_i;
    logic        din_bit_one_i, din_bit_two_i, din_bit_three_i, gate0_i, gate1_i, gate2_i;
    logic [11:0] adc_code_i, dac0_code_o, dac1_code_o;
    logic [15:0] dac_data_i, dout_data_i, cnt_data_i, adc_word_o, din_word_o, cnt0_value_o, cnt1_value_o, cnt2_value_o;
    logic [1:0]  cnt_sel_i, pace_src_i;
    logic [2:0]  chain;
    logic        adc_word_valid_o, dout_bit_zero_o, dout_bit_one_o, dout_bit_two_o, dout_bit_three_o;
    logic        counter_zero_out_o, counter_one_out_o, pacer_counter_out_o, pace_tick_o;
    wire         counter_zero_clock_in_i, counter_one_clock_in_i, ext_pace_i;
    int          err_total, checked, cycles, n;
    logic [3:0]  dout;
    assign dout = {dout_bit_three_o, dout_bit_two_o, dout_bit_one_o, dout_bit_zero_o};
    daq_core dut (.sys_clk_i, .nrst_i, .adc_valid_i, .adc_code_i, .adc_word_o, .adc_word_valid_o,
        .dac0_wr_i, .dac1_wr_i, .dac_data_i, .dac0_code_o, .dac1_code_o, .dout_wr_i, .dout_data_i,
        .din_bit_one_i, .din_bit_two_i, .din_bit_three_i, .din_word_o, .dout_bit_zero_o, .dout_bit_one_o,
        .dout_bit_two_o, .dout_bit_three_o, .cnt_wr_i, .cnt_sel_i, .cnt_data_i, .ctr2_osc_sel_i, .pace_src_i,
        .counter_zero_clock_in_i, .counter_one_clock_in_i, .gate0_i, .gate1_i, .gate2_i, .ext_pace_i,
        .counter_zero_out_o, .counter_one_out_o, .pacer_counter_out_o, .pace_tick_o, .cnt0_value_o,
        .cnt1_value_o, .cnt2_value_o);
    host_wiring wiring (.sys_clk_i, .nrst_i, .chain_i(chain), .pacer_counter_out_i(pacer_counter_out_o),
        .counter_zero_clock_in_o(counter_zero_clock_in_i), .counter_one_clock_in_o(counter_one_clock_in_i),
        .ext_pace_o(ext_pace_i));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic load(input logic [1:0] sel, input logic [15:0] val);
        @(posedge sys_clk_i);
        cnt_wr_i   <= 1'b1;
        cnt_sel_i  <= sel;
        cnt_data_i <= val;
        @(posedge sys_clk_i);
        cnt_wr_i <= 1'b0;
    endtask
    // Cycles between two pace ticks; the first tick only sets the phase
    task automatic span(output int len);
        for (int k = 0; k < 300 && pace_tick_o !== 1'b1; k++)
            @(posedge sys_clk_i) #1;
        @(posedge sys_clk_i) #1;
        for (len = 1; len < 300 && pace_tick_o !== 1'b1; len++)
            @(posedge sys_clk_i) #1;
    endtask
    task automatic dac_wr(input logic ch, input logic [15:0] d, input logic [11:0] other);
        @(posedge sys_clk_i);
        dac0_wr_i  <= !ch;
        dac1_wr_i  <= ch;
        dac_data_i <= d;
        @(posedge sys_clk_i);
        dac0_wr_i <= 1'b0;
        dac1_wr_i <= 1'b0;
        #1;
        check16("dac written", {4'h0, d[11:0]}, {4'h0, ch ? dac1_code_o : dac0_code_o});
        check16("dac other", {4'h0, other}, {4'h0, ch ? dac0_code_o : dac1_code_o});
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check16("dac0 reset", 16'h0000, {4'h0, dac0_code_o});
        check16("dout reset", 16'h0000, {12'h000, dout});
        check16("outs idle", 16'h0007, {13'h0, counter_zero_out_o, counter_one_out_o, pacer_counter_out_o});
        check16("cnt1 reset", 16'hFFFF, cnt1_value_o);
        check16("cnt2 reset", 16'hFFFF, cnt2_value_o);
        check16("cnt0 reset", 16'hFFFF, cnt0_value_o);
    endtask
    task automatic t_init();
        for (int s = 0; s < 3; s++)
            load(2'(s), 16'hFFFF);
        dac_wr(1'b0, 16'h0000, 12'h000);
        dac_wr(1'b1, 16'h0000, 12'h000);
        @(posedge sys_clk_i);
        dout_wr_i   <= 1'b1;
        dout_data_i <= 16'h0000;
        @(posedge sys_clk_i);
        dout_wr_i <= 1'b0;
        #1;
        check16("dout init", 16'h0000, {12'h000, dout});
    endtask
    task automatic t_adc();
        logic [11:0] codes [3] = '{12'h000, 12'h800, 12'hFFF};
        logic [15:0] ints [3]  = '{16'hF800, 16'h0000, 16'h07FF};
        foreach (codes[i])
        begin
            @(posedge sys_clk_i);
            adc_valid_i <= 1'b1;
            adc_code_i  <= codes[i];
            @(posedge sys_clk_i);
            adc_valid_i <= 1'b0;
            #1;
            check16("adc word", {codes[i], 4'h0}, adc_word_o);
            check16("adc integer", ints[i], (adc_word_o >> 4) - 16'h0800);
            check16("adc valid", 16'h0001, {15'h0, adc_word_valid_o});
        end
        @(posedge sys_clk_i) #1;
        check16("adc valid end", 16'h0000, {15'h0, adc_word_valid_o});
    endtask
    task automatic t_dac();
        dac_wr(1'b0, 16'h1FFF, 12'h000);
        dac_wr(1'b1, 16'h1000, 12'hFFF);
        dac_wr(1'b1, 16'h0800, 12'hFFF);
        dac_wr(1'b0, 16'hFFFF, 12'h800);
    endtask
    task automatic t_dio();
        logic [15:0] dw [2] = '{16'hFFFA, 16'h0015};
        logic [2:0]  di [2] = '{3'h5, 3'h2};
        for (int i = 0; i < 2; i++)
        begin
            @(posedge sys_clk_i);
            dout_wr_i       <= 1'b1;
            dout_data_i     <= dw[i];
            din_bit_three_i <= di[i][2];
            din_bit_two_i   <= di[i][1];
            din_bit_one_i   <= di[i][0];
            @(posedge sys_clk_i);
            dout_wr_i <= 1'b0;
            #1;
            check16("dout", {12'h000, dw[i][3:0]}, {12'h000, dout});
            check16("din word", {13'h0, di[i]}, din_word_o);
        end
    endtask
    task automatic t_pacer();
        pace_src_i <= PACE_CTR2;
        load(SEL_CTR2, 16'h0003);
        span(n);
        check16("pace interval", 16'h0003, 16'(n));
        check16("pacer out low", 16'h0000, {15'h0, pacer_counter_out_o});
        @(posedge sys_clk_i) #1;
        check16("pacer out high", 16'h0001, {15'h0, pacer_counter_out_o});
        ctr2_osc_sel_i <= 1'b1;
        load(SEL_CTR2, 16'h0002);
        span(n);
        check16("osc interval", 16'(2 * OSC_DIV), 16'(n));
        ctr2_osc_sel_i <= 1'b0;
        load(SEL_CTR2, 16'h0003);
    endtask
    task automatic t_gate();
        logic [15:0] held;
        int ticks;
        @(posedge sys_clk_i);
        gate2_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        #1;
        held  = cnt2_value_o;
        ticks = 0;
        repeat (10)
        begin
            @(posedge sys_clk_i) #1;
            ticks += int'(pace_tick_o === 1'b1);
        end
        check16("gated count", held, cnt2_value_o);
        check16("gated ticks", 16'h0000, 16'(ticks));
        gate2_i <= 1'b1;
        span(n);
        check16("resumed interval", 16'h0003, 16'(n));
    endtask
    // Host-timed analog updates, one every second pace tick of period three
    task automatic t_dac_paced();
        span(n);
        check16("paced interval", 16'h0003, 16'(n));
        dac_wr(1'b0, 16'h0ABC, 12'h800);
        span(n);
        dac_wr(1'b1, 16'h0123, 12'hABC);
    endtask
    task automatic t_chain();
        for (int s = 0; s < 3; s++)
            load(2'(s), 16'h0002);
        pace_src_i <= PACE_CHAIN;
        for (int m = 3; m < 5; m++)
        begin
            chain <= 3'(m);
            span(n);
            span(n);
            check16("chain interval", 16'h0004, 16'(n));
        end
        pace_src_i <= PACE_EXT;
        chain      <= 3'h6;
        span(n);
        span(n);
        check16("ext interval", 16'h0004, 16'(n));
        chain <= 3'h0;
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = !sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_total++;
            print_verdict();
        end
    end
    initial
    begin
        {nrst_i, adc_valid_i, dac0_wr_i, dac1_wr_i, dout_wr_i, cnt_wr_i, ctr2_osc_sel_i} = 7'h00;
        {din_bit_one_i, din_bit_two_i, din_bit_three_i} = 3'h0;
        {gate0_i, gate1_i, gate2_i} = 3'h7;
        {adc_code_i, dac_data_i, dout_data_i, cnt_data_i, cnt_sel_i, pace_src_i, chain} = '0;
        repeat (5) @(posedge sys_clk_i);
        #1;
        t_reset();
        @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        t_init();
        t_adc();
        t_dac();
        t_dio();
        t_pacer();
        t_gate();
        t_dac_paced();
        t_chain();
        print_verdict();
    end
endmodule // testbench
